// ===== src/lrdo_lane_if.sv
// Captured per-lane receive state passed from a lane tap to the observer core
`timescale 1ns/1ps
`include "lrdo_params.svh"

interface lrdo_lane_if;
    logic [`LRDO_FILL_WIDTH-1:0] fill_count;
    logic [`LRDO_CODE_WIDTH-1:0] code;
    logic invert_req;
    logic deskew_ovf;
    logic rx_err;

    modport tap (output fill_count, output code, output invert_req,
                 output deskew_ovf, output rx_err);
    modport core (input fill_count, input code, input invert_req,
                  input deskew_ovf, input rx_err);
endinterface

// ===== src/lrdo_lane_tap.sv
// Registers one lane's receive path state and flags its error events
`timescale 1ns/1ps
`include "lrdo_params.svh"

module lrdo_lane_tap (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Lane receive path state
    input wire logic [`LRDO_FILL_WIDTH-1:0] fill_count,
    input wire logic [`LRDO_CODE_WIDTH-1:0] rx_code,
    input wire logic invert_req,
    input wire logic deskew_ovf,
    input wire logic generic_phy,
    // Captured state
    lrdo_lane_if.tap lane
);

    // Codes 100 to 111 are errors; 000 to 011 are normal reports
    function automatic logic lrdo_is_error(input lrdo_pkg::lrdo_rx_code_t c);
        unique case (c)
            lrdo_pkg::LRDO_RX_DECODE, lrdo_pkg::LRDO_RX_EB_OVF,
            lrdo_pkg::LRDO_RX_EB_UNF, lrdo_pkg::LRDO_RX_DISPARITY: lrdo_is_error = 1'b1;
            default: lrdo_is_error = 1'b0;
        endcase
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane.deskew_ovf <= 1'b0;
        end else if (clk_en) begin
            lane.deskew_ovf <= deskew_ovf;
        end
    end

    // With a generic external PHY these fields mean nothing; they read zero then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane.fill_count <= '0;
            lane.code <= '0;
            lane.invert_req <= 1'b0;
            lane.rx_err <= 1'b0;
        end else if (clk_en) begin
            if (generic_phy) begin
                lane.fill_count <= '0;
                lane.code <= '0;
                lane.invert_req <= 1'b0;
                lane.rx_err <= 1'b0;
            end else begin
                lane.fill_count <= fill_count;
                lane.code <= rx_code;
                lane.invert_req <= invert_req;
                lane.rx_err <= lrdo_is_error(lrdo_pkg::lrdo_rx_code_t'(rx_code));
            end
        end
    end

endmodule

// ===== src/lrdo_params.svh
// Offsets, field positions, reset values and widths of the lane receive debug observer
`ifndef LRDO_PARAMS_SVH
`define LRDO_PARAMS_SVH

// Register byte offsets
`define LRDO_OFS_STATUS 12'h000
`define LRDO_OFS_MASK 12'h004
`define LRDO_OFS_CTRL 12'h008
`define LRDO_OFS_SLICE_LO 12'h00C
`define LRDO_OFS_SLICE_MID 12'h010
`define LRDO_OFS_SLICE_HI 12'h014

// Status and mask layout
`define LRDO_ST_DESKEW_LSB 0
`define LRDO_ST_RXERR_LSB 4
`define LRDO_ST_RETRAIN_BIT 8
`define LRDO_ST_WIDTH 9

// Control layout and reset
`define LRDO_CTRL_RETRAIN_EN_BIT 0
`define LRDO_CTRL_GENERIC_PHY_BIT 1
`define LRDO_CTRL_WIDTH 2
`define LRDO_CTRL_RESET 2'h1
`define LRDO_MASK_RESET 9'h000

// Debug slice layout, relative to bus bit 440
`define LRDO_SLICE_BASE 440
`define LRDO_SLICE_WIDTH 72
`define LRDO_DESKEW_FLD_LSB 0
`define LRDO_DESKEW_FLD_WIDTH 8
`define LRDO_LANE_FLD_LSB 8
`define LRDO_LANE_FLD_WIDTH 8
`define LRDO_FILL_OFS 0
`define LRDO_CODE_OFS 4
`define LRDO_INV_OFS 7
`define LRDO_RSVD_LSB 40
`define LRDO_RSVD_WIDTH 32

// Per-lane widths
`define LRDO_NUM_LANES 4
`define LRDO_FILL_WIDTH 4
`define LRDO_CODE_WIDTH 3

`endif

// ===== src/lrdo_pkg.sv
// Types of the lane receive debug observer
package lrdo_pkg;

    typedef enum logic [2:0] {
        LRDO_RX_OK        = 3'h0,
        LRDO_RX_SKP_ADD   = 3'h1,
        LRDO_RX_SKP_DEL   = 3'h2,
        LRDO_RX_DETECTED  = 3'h3,
        LRDO_RX_DECODE    = 3'h4,
        LRDO_RX_EB_OVF    = 3'h5,
        LRDO_RX_EB_UNF    = 3'h6,
        LRDO_RX_DISPARITY = 3'h7
    } lrdo_rx_code_t;

    typedef enum logic [1:0] {
        LRDO_RT_IDLE = 2'h0,
        LRDO_RT_REQ  = 2'h1,
        LRDO_RT_WAIT = 2'h2
    } lrdo_retrain_t;

endpackage

// ===== src/lrdo_top.sv
// Lane receive debug observer: debug bus bits 440 to 511 with APB status and control
//
// Functional notes
// - Bits 447:440 flag a deskew FIFO overflow on each physical lane.
// - A deskew overflow is a receive port error and requests link retraining.
// - The upper four deskew flag bits are always zero; only four lanes.
// - Lanes 0 and 1 elastic buffer fill counts at 451:448 and 459:456.
// - Lanes 2 and 3 elastic buffer fill counts at 467:464 and 475:472.
// - Lane 0 three-bit receive status code at 454:452.
// - Lanes 1 to 3 receive status codes at 462:460, 470:468, 478:476.
// - Codes: 000 ok, 001 skip added, 010 skip removed, 011 receiver detected.
// - Codes: 100 decode, 101 buffer overflow, 110 underflow, 111 disparity error.
// - Bit 455 is the lane 0 request to invert received 10-bit data.
// - Bits 463, 471, 479 are the same invert request for lanes 1 to 3.
// - With a generic external PHY, counts, codes and invert bits are meaningless.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "lrdo_params.svh"

module lrdo_top #(
    parameter int NUM_LANES = `LRDO_NUM_LANES
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive path state, same clock domain
    input wire logic [NUM_LANES-1:0] deskew_ovf,
    input wire logic [`LRDO_FILL_WIDTH-1:0] elastic_fill_count_lane0,
    input wire logic [`LRDO_FILL_WIDTH-1:0] elastic_fill_count_lane1,
    input wire logic [`LRDO_FILL_WIDTH-1:0] elastic_fill_count_lane2,
    input wire logic [`LRDO_FILL_WIDTH-1:0] elastic_fill_count_lane3,
    input wire logic [`LRDO_CODE_WIDTH-1:0] lane_rx_status_code0,
    input wire logic [`LRDO_CODE_WIDTH-1:0] lane_rx_status_code1,
    input wire logic [`LRDO_CODE_WIDTH-1:0] lane_rx_status_code2,
    input wire logic [`LRDO_CODE_WIDTH-1:0] lane_rx_status_code3,
    input wire logic lane_invert_request0,
    input wire logic lane_invert_request1,
    input wire logic lane_invert_request2,
    input wire logic lane_invert_request3,
    // Retraining handshake with link training
    input wire logic retrain_ack,
    output logic retrain_req,
    output logic rx_port_error,
    // Debug slice, bit 0 is bus bit 440
    output logic [`LRDO_SLICE_WIDTH-1:0] debug_slice,
    // Interrupt
    output logic irq
);

    logic [`LRDO_FILL_WIDTH-1:0] fill_in [NUM_LANES];
    logic [`LRDO_CODE_WIDTH-1:0] code_in [NUM_LANES];
    logic [NUM_LANES-1:0] inv_in;
    logic [NUM_LANES-1:0] ovf_cap;
    logic [NUM_LANES-1:0] err_cap;
    logic [`LRDO_LANE_FLD_WIDTH-1:0] lane_fld [NUM_LANES];

    logic [`LRDO_ST_WIDTH-1:0] status_q;
    logic [`LRDO_ST_WIDTH-1:0] mask_q;
    logic [`LRDO_CTRL_WIDTH-1:0] ctrl_q;
    logic [NUM_LANES-1:0] deskew_flag_q;
    logic [`LRDO_SLICE_WIDTH-1:0] slice_d;
    logic [`LRDO_ST_WIDTH-1:0] st_set;
    logic [`LRDO_ST_WIDTH-1:0] st_clr;
    lrdo_pkg::lrdo_retrain_t rt_q;
    logic any_ovf;
    logic retrain_start;
    logic wr_en;
    logic setup;
    logic [5:0] wr_sel;

    assign fill_in[0] = elastic_fill_count_lane0;
    assign fill_in[1] = elastic_fill_count_lane1;
    assign fill_in[2] = elastic_fill_count_lane2;
    assign fill_in[3] = elastic_fill_count_lane3;
    assign code_in[0] = lane_rx_status_code0;
    assign code_in[1] = lane_rx_status_code1;
    assign code_in[2] = lane_rx_status_code2;
    assign code_in[3] = lane_rx_status_code3;
    assign inv_in = {lane_invert_request3, lane_invert_request2,
                     lane_invert_request1, lane_invert_request0};

    // One tap per lane; each packs its byte of the slice
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LANES; gi++) begin : g_lane
            lrdo_lane_if lane_bus ();

            lrdo_lane_tap u_tap (
                .pclk(pclk),
                .presetn(presetn),
                .clk_en(clk_en),
                .fill_count(fill_in[gi]),
                .rx_code(code_in[gi]),
                .invert_req(inv_in[gi]),
                .deskew_ovf(deskew_ovf[gi]),
                .generic_phy(ctrl_q[`LRDO_CTRL_GENERIC_PHY_BIT]),
                .lane(lane_bus.tap)
            );

            assign ovf_cap[gi] = lane_bus.deskew_ovf;
            assign err_cap[gi] = lane_bus.rx_err;
            assign lane_fld[gi] = {lane_bus.invert_req, lane_bus.code, lane_bus.fill_count};
        end
    endgenerate

    // One-hot register select from the byte address; zero when unmapped
    function automatic logic [5:0] reg_sel(input logic [11:0] a);
        logic [5:0] s;
        s = 6'h00;
        unique case (a)
            `LRDO_OFS_STATUS: s = 6'h01;
            `LRDO_OFS_MASK: s = 6'h02;
            `LRDO_OFS_CTRL: s = 6'h04;
            `LRDO_OFS_SLICE_LO: s = 6'h08;
            `LRDO_OFS_SLICE_MID: s = 6'h10;
            `LRDO_OFS_SLICE_HI: s = 6'h20;
            default: s = 6'h00;
        endcase
        return s;
    endfunction

    // Any lane overflow feeds both the port error and the retrain start
    assign any_ovf = |ovf_cap;
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    // Write strobe per register, only at the access edge
    assign wr_sel = wr_en ? reg_sel(paddr) : 6'h00;

    // Events set status bits; set wins over a same-cycle write-one clear
    always_comb begin
        st_set = '0;
        st_set[`LRDO_ST_DESKEW_LSB +: NUM_LANES] = ovf_cap;
        st_set[`LRDO_ST_RXERR_LSB +: NUM_LANES] = err_cap;
        st_set[`LRDO_ST_RETRAIN_BIT] = retrain_start;
        st_clr = '0;
        if (wr_sel[0]) begin
            st_clr = pwdata[`LRDO_ST_WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
        end else if (clk_en) begin
            status_q <= (status_q & ~st_clr) | st_set;
        end
    end

    // Deskew flags on the bus hold until software clears the matching status bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deskew_flag_q <= '0;
        end else if (clk_en) begin
            deskew_flag_q <= (deskew_flag_q & ~st_clr[`LRDO_ST_DESKEW_LSB +: NUM_LANES])
                | ovf_cap;
        end
    end

    // Mask register, same layout as status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= `LRDO_MASK_RESET;
        end else if (clk_en && wr_sel[1]) begin
            mask_q <= pwdata[`LRDO_ST_WIDTH-1:0];
        end
    end

    // Control: bit 0 retrain enable, bit 1 generic PHY
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `LRDO_CTRL_RESET;
        end else if (clk_en && wr_sel[2]) begin
            ctrl_q <= pwdata[`LRDO_CTRL_WIDTH-1:0];
        end
    end

    // Level interrupt from the next status value, so set and clear show at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |((status_q & ~st_clr | st_set) & mask_q);
        end
    end

    // Overflow is a receive port error and starts retraining
    assign retrain_start = any_ovf && ctrl_q[`LRDO_CTRL_RETRAIN_EN_BIT]
        && rt_q == lrdo_pkg::LRDO_RT_IDLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_port_error <= 1'b0;
        end else if (clk_en) begin
            rx_port_error <= any_ovf;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rt_q <= lrdo_pkg::LRDO_RT_IDLE;
        end else if (clk_en) begin
            unique case (rt_q)
                lrdo_pkg::LRDO_RT_IDLE: begin
                    if (retrain_start) begin
                        rt_q <= lrdo_pkg::LRDO_RT_REQ;
                    end
                end
                lrdo_pkg::LRDO_RT_REQ: begin
                    if (retrain_ack) begin
                        rt_q <= lrdo_pkg::LRDO_RT_WAIT;
                    end
                end
                lrdo_pkg::LRDO_RT_WAIT: begin
                    // Wait for the ack to fall so one overflow burst gives one request
                    if (!retrain_ack) begin
                        rt_q <= lrdo_pkg::LRDO_RT_IDLE;
                    end
                end
                default: begin
                    rt_q <= lrdo_pkg::LRDO_RT_IDLE;
                end
            endcase
        end
    end

    // Request stands from the start of a retrain until the link acknowledges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retrain_req <= 1'b0;
        end else if (clk_en) begin
            retrain_req <= retrain_start
                || (rt_q == lrdo_pkg::LRDO_RT_REQ && !retrain_ack);
        end
    end

    // Slice assembly
    always_comb begin
        slice_d = '0;
        slice_d[`LRDO_DESKEW_FLD_LSB +: NUM_LANES] = deskew_flag_q;
        slice_d[`LRDO_DESKEW_FLD_LSB + NUM_LANES +: 4] = 4'h0;
        for (int i = 0; i < NUM_LANES; i++) begin
            slice_d[`LRDO_LANE_FLD_LSB + i*`LRDO_LANE_FLD_WIDTH +: `LRDO_LANE_FLD_WIDTH]
                = lane_fld[i];
        end
        slice_d[`LRDO_RSVD_LSB +: `LRDO_RSVD_WIDTH] = 32'h00000000;
    end

    // Registered so every debug bus bit comes straight from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            debug_slice <= '0;
        end else if (clk_en) begin
            debug_slice <= slice_d;
        end
    end

    // APB: one wait-free access phase, read data latched in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else if (clk_en) begin
            pready <= setup;
        end
    end

    // Error answer for an unmapped address stands with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pslverr <= setup && reg_sel(paddr) == 6'h00;
        end
    end

    // Read data is latched at the setup edge and stands until the next setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (clk_en && setup) begin
            prdata <= 32'h00000000;
            unique case (paddr)
                `LRDO_OFS_STATUS: prdata[`LRDO_ST_WIDTH-1:0] <= status_q;
                `LRDO_OFS_MASK: prdata[`LRDO_ST_WIDTH-1:0] <= mask_q;
                `LRDO_OFS_CTRL: prdata[`LRDO_CTRL_WIDTH-1:0] <= ctrl_q;
                `LRDO_OFS_SLICE_LO: prdata <= debug_slice[31:0];
                `LRDO_OFS_SLICE_MID: prdata <= debug_slice[63:32];
                `LRDO_OFS_SLICE_HI: prdata[7:0] <= debug_slice[71:64];
                default: prdata <= 32'h00000000;
            endcase
        end
    end

endmodule

// ===== verification/lrdo_link_model.sv
// Link training responder that acknowledges retrain requests after a set delay
`timescale 1ns/1ps

module lrdo_link_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Handshake
    input wire logic [3:0] ack_delay,
    input wire logic retrain_req,
    output logic retrain_ack
);
    logic [3:0] wait_q;

    // Ack is held until the request drops, then released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 4'h0;
            retrain_ack <= 1'b0;
        end else if (!retrain_req) begin
            wait_q <= 4'h0;
            retrain_ack <= 1'b0;
        end else if (wait_q >= ack_delay) begin
            retrain_ack <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

// ===== verification/lrdo_top_chk.sv
// Concurrent checks on the lane receive debug observer ports
`timescale 1ns/1ps
`include "lrdo_params.svh"

module lrdo_top_chk #(
    parameter int NUM_LANES = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Lane state
    input wire logic [NUM_LANES-1:0] deskew_ovf,
    input wire logic [3:0] elastic_fill_count_lane0,
    input wire logic [3:0] elastic_fill_count_lane1,
    input wire logic [3:0] elastic_fill_count_lane2,
    input wire logic [3:0] elastic_fill_count_lane3,
    input wire logic [2:0] lane_rx_status_code0,
    input wire logic [2:0] lane_rx_status_code1,
    input wire logic [2:0] lane_rx_status_code2,
    input wire logic [2:0] lane_rx_status_code3,
    input wire logic lane_invert_request0,
    input wire logic lane_invert_request1,
    input wire logic lane_invert_request2,
    input wire logic lane_invert_request3,
    // Outputs
    input wire logic retrain_req,
    input wire logic rx_port_error,
    input wire logic [71:0] debug_slice
);
    logic [1:0] ctl_q;
    logic [1:0] up_q;

    // Shadow of the control register and cycles since reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 2'h1;
            up_q <= 2'h0;
        end else begin
            if (up_q != 2'h3) begin
                up_q <= up_q + 2'h1;
            end
            if (psel && penable && pready && pwrite && paddr == `LRDO_OFS_CTRL) begin
                ctl_q <= pwdata[1:0];
            end
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rsvd;
        debug_slice[71:40] == 32'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_hi4;
        debug_slice[7:4] == 4'h0;
    endproperty
    a_hi4: assert property (p_hi4) else $error("upper deskew flags set");
    property p_lane0;
        up_q == 2'h3 && !ctl_q[1] && !$past(ctl_q[1]) && !$past(ctl_q[1], 2)
        |-> debug_slice[15:8] == $past({lane_invert_request0, lane_rx_status_code0,
            elastic_fill_count_lane0}, 2);
    endproperty
    a_lane0: assert property (p_lane0) else $error("lane 0 byte wrong");
    property p_lane123;
        up_q == 2'h3 && !ctl_q[1] && !$past(ctl_q[1]) && !$past(ctl_q[1], 2)
        |-> debug_slice[39:16] == $past({lane_invert_request3, lane_rx_status_code3,
            elastic_fill_count_lane3, lane_invert_request2, lane_rx_status_code2,
            elastic_fill_count_lane2, lane_invert_request1, lane_rx_status_code1,
            elastic_fill_count_lane1}, 2);
    endproperty
    a_lane123: assert property (p_lane123) else $error("lane 1-3 bytes wrong");
    property p_gen;
        up_q == 2'h3 && ctl_q[1] && $past(ctl_q[1]) && $past(ctl_q[1], 2)
        |-> debug_slice[39:8] == 32'h0;
    endproperty
    a_gen: assert property (p_gen) else $error("generic fields not zero");
    property p_dsk;
        deskew_ovf[0] |-> ##[2:3] debug_slice[0];
    endproperty
    a_dsk: assert property (p_dsk) else $error("deskew flag missing");
    property p_perr;
        |deskew_ovf |-> ##2 rx_port_error;
    endproperty
    a_perr: assert property (p_perr) else $error("port error missing");
    property p_retr;
        $rose(retrain_req) |-> rx_port_error && ctl_q[0];
    endproperty
    a_retr: assert property (p_retr) else $error("retrain without cause");
endmodule

bind lrdo_top lrdo_top_chk #(.NUM_LANES(NUM_LANES)) i_lrdo_top_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .deskew_ovf,
    .elastic_fill_count_lane0, .elastic_fill_count_lane1, .elastic_fill_count_lane2,
    .elastic_fill_count_lane3, .lane_rx_status_code0, .lane_rx_status_code1,
    .lane_rx_status_code2, .lane_rx_status_code3, .lane_invert_request0,
    .lane_invert_request1, .lane_invert_request2, .lane_invert_request3,
    .retrain_req, .rx_port_error, .debug_slice
);

// ===== verification/lrdo_top_tb.sv
// Self-checking bench for the lane receive debug observer
`timescale 1ns/1ps
`include "lrdo_params.svh"

module lrdo_top_tb;
    logic pclk, presetn, clk_en, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, rerr, retrain_ack, retrain_req, rx_port_error, irq;
    logic [3:0] dsk, inv, lat;
    logic [3:0][3:0] fill;
    logic [3:0][2:0] code;
    logic [71:0] debug_slice;
    int fail_count = 0;
    int comparisons = 0;

    lrdo_top i_lrdo_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .deskew_ovf(dsk),
        .elastic_fill_count_lane0(fill[0]), .elastic_fill_count_lane1(fill[1]),
        .elastic_fill_count_lane2(fill[2]), .elastic_fill_count_lane3(fill[3]),
        .lane_rx_status_code0(code[0]), .lane_rx_status_code1(code[1]),
        .lane_rx_status_code2(code[2]), .lane_rx_status_code3(code[3]),
        .lane_invert_request0(inv[0]), .lane_invert_request1(inv[1]),
        .lane_invert_request2(inv[2]), .lane_invert_request3(inv[3]),
        .retrain_ack(retrain_ack), .retrain_req(retrain_req),
        .rx_port_error(rx_port_error), .debug_slice(debug_slice), .irq(irq));

    lrdo_link_model i_lrdo_link_model (.pclk(pclk), .presetn(presetn), .ack_delay(lat),
        .retrain_req(retrain_req), .retrain_ack(retrain_ack));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            $display("unexpected at %0t: no pready", $time);
            fail_count++;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask

    task automatic slc(input logic [71:0] e);
        rd(`LRDO_OFS_SLICE_LO, e[31:0]);
        rd(`LRDO_OFS_SLICE_MID, e[63:32]);
        rd(`LRDO_OFS_SLICE_HI, {24'h0, e[71:64]});
    endtask

    task automatic pulse(input logic [3:0] v);
        @(posedge pclk);
        dsk <= v;
        @(posedge pclk);
        dsk <= 4'h0;
        repeat (4) @(posedge pclk);
    endtask

    function automatic logic [71:0] exp_slice();
        logic [71:0] e;
        e = 72'h0;
        for (int n = 0; n < 4; n++)
            e[8+8*n +: 8] = {inv[n], code[n], fill[n]};
        return e;
    endfunction

    initial begin
        repeat (20000) @(posedge pclk);
        $display("unexpected at %0t: watchdog expired", $time);
        fail_count++;
        give_verdict();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, dsk, inv, fill, code} = '0;
        clk_en = 1'b1;
        lat = 4'h6;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`LRDO_OFS_CTRL, 32'h1);
        rd(`LRDO_OFS_MASK, 32'h0);
        rd(`LRDO_OFS_STATUS, 32'h0);
        slc(72'h0);
        xfer(1'b0, 12'h018, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
        // Every receive status code on every lane, fill counts up to 15
        for (int k = 0; k < 8; k++) begin
            @(posedge pclk);
            for (int n = 0; n < 4; n++) begin
                code[n] <= k[2:0];
                fill[n] <= 4'(k * 2 + n);
                inv[n] <= k[0] ^ n[0];
            end
            repeat (3) @(posedge pclk);
            slc(exp_slice());
            xfer(1'b1, `LRDO_OFS_STATUS, 32'hF0);
            rd(`LRDO_OFS_STATUS, (k >= 4) ? 32'hF0 : 32'h0);
        end
        xfer(1'b1, `LRDO_OFS_CTRL, 32'h3);
        repeat (3) @(posedge pclk);
        slc(72'h0);
        xfer(1'b1, `LRDO_OFS_STATUS, 32'h1FF);
        rd(`LRDO_OFS_STATUS, 32'h0);
        {inv, fill, code} <= '0;
        xfer(1'b1, `LRDO_OFS_CTRL, 32'h1);
        xfer(1'b1, `LRDO_OFS_MASK, 32'h1);
        pulse(4'h1);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, retrain_req}, 32'h1);
        rd(`LRDO_OFS_STATUS, 32'h101);
        slc(72'h1);
        xfer(1'b1, `LRDO_OFS_STATUS, 32'h1FF);
        lat <= 4'h0;
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        slc(72'h0);
        pulse(4'h8);
        chk({31'h0, irq}, 32'h0);
        rd(`LRDO_OFS_STATUS, 32'h108);
        slc(72'h8);
        xfer(1'b1, `LRDO_OFS_CTRL, 32'h0);
        xfer(1'b1, `LRDO_OFS_STATUS, 32'h1FF);
        pulse(4'h2);
        rd(`LRDO_OFS_STATUS, 32'h2);
        give_verdict();
    end
endmodule
